//--- design/smfs_pkg.sv
// Purpose: shared constants and types for the motion fault supervisor
// Assumes: 32-bit apb data, one word per register
// Notes:   offsets are byte addresses
package smfs_pkg;

    // register byte offsets
    localparam logic [7:0] SMFS_OFS_CTRL    = 8'h00;
    localparam logic [7:0] SMFS_OFS_CMD     = 8'h04;
    localparam logic [7:0] SMFS_OFS_TARGET  = 8'h08;
    localparam logic [7:0] SMFS_OFS_SECURE  = 8'h0c;
    localparam logic [7:0] SMFS_OFS_STATUS  = 8'h10;
    localparam logic [7:0] SMFS_OFS_ACTUAL  = 8'h14;
    localparam logic [7:0] SMFS_OFS_VEL     = 8'h18;
    localparam logic [7:0] SMFS_OFS_DUALVEL = 8'h1c;
    localparam logic [7:0] SMFS_OFS_SNAP    = 8'h20;

    // ctrl field positions
    localparam int SMFS_CTRL_JITTER = 0;
    localparam int SMFS_CTRL_PWMSEL = 6;
    localparam int SMFS_CTRL_SHAPE  = 8;

    // command codes, written to the command register
    localparam logic [3:0] SMFS_CMD_NONE     = 4'h0;
    localparam logic [3:0] SMFS_CMD_STATUS   = 4'h1;
    localparam logic [3:0] SMFS_CMD_SETPOS   = 4'h2;
    localparam logic [3:0] SMFS_CMD_GOSEC    = 4'h3;
    localparam logic [3:0] SMFS_CMD_CLRPOS   = 4'h4;
    localparam logic [3:0] SMFS_CMD_DUAL     = 4'h5;
    localparam logic [3:0] SMFS_CMD_HARD     = 4'h6;
    localparam logic [3:0] SMFS_CMD_SOFT     = 4'h7;
    localparam logic [3:0] SMFS_CMD_DEFAULTS = 4'h8;

    // widths and reset values
    localparam int          SMFS_POS_W       = 16;
    localparam logic [10:0] SMFS_SEC_DISABLE = 11'h400;
    localparam logic [7:0]  SMFS_VEL_RESET   = 8'h00;

    // stabilization time, 1000 us at 250 MHz
    localparam int SMFS_CLK_MHZ     = 250;
    localparam int SMFS_STAB_US     = 1000;
    localparam int SMFS_STAB_CYCLES = SMFS_STAB_US * SMFS_CLK_MHZ;

    // open coil: full duty for this many cycles
    localparam int SMFS_OPEN_US     = 200;
    localparam int SMFS_OPEN_CYCLES = SMFS_OPEN_US * SMFS_CLK_MHZ;

    // coil current level selection
    localparam logic [1:0] SMFS_AMP_OFF  = 2'b00;
    localparam logic [1:0] SMFS_AMP_HOLD = 2'b01;
    localparam logic [1:0] SMFS_AMP_RUN  = 2'b10;

    typedef enum logic [2:0]
    {
        SMFS_ST_SHUTDOWN = 3'b000,
        SMFS_ST_STOPPED  = 3'b001,
        SMFS_ST_MOVING   = 3'b010,
        SMFS_ST_DUAL     = 3'b011,
        SMFS_ST_HARD     = 3'b100,
        SMFS_ST_RAMPED   = 3'b101
    } smfs_state_type;

endpackage : smfs_pkg

//--- design/smfs_sync.sv
// Purpose: two-flop synchroniser for a bus of levels
// Assumes: inputs are slow levels from outside the clock domain
// Notes:   first stage is read only by the second
`timescale 1ns/1ns
module smfs_sync
#(
    parameter int WIDTH = 1
)
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // two stages, cleared on reset
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : smfs_sync

//--- design/smfs_supervisor.sv
// Purpose: motion state and fault supervisor of a stepper driver
// Assumes: apb slave, analogue fault levels arrive asynchronously
// Notes:   step generation lives outside; this block steers it
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
module smfs_supervisor
#(
    parameter int STAB_CYCLES = smfs_pkg::SMFS_STAB_CYCLES,
    parameter int OPEN_CYCLES = smfs_pkg::SMFS_OPEN_CYCLES
)
(
    // clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            rst_n,
    // apb slave
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [7:0]                      paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // analogue monitors, asynchronous
    input  wire logic                            thermal_hot,
    input  wire logic                            uv2_low,
    input  wire logic                            pump_low,
    input  wire logic                            supply_reset_seen,
    input  wire logic [1:0]                      bridge_drop,
    input  wire logic [1:0]                      coil_full_duty,
    // motion engine
    input  wire logic [smfs_pkg::SMFS_POS_W-1:0] actual_position,
    input  wire logic                            decel_done,
    input  wire logic                            dual_phase_two,
    input  wire logic                            dual_done,
    // drive outputs
    output logic [1:0]                           bridge_open,
    output logic [1:0]                           amp_select,
    output logic [smfs_pkg::SMFS_POS_W-1:0]      target_position,
    output logic                                 pwm_rate_select,
    output logic                                 pwm_jitter_enable,
    output logic                                 acceleration_shape,
    output logic [2:0]                           motion_state
);
    import smfs_pkg::*;

    localparam int CW = $clog2(STAB_CYCLES + OPEN_CYCLES + 1);

    smfs_state_type state_reg;
    smfs_state_type state_next;

    logic [3:0]            mon_s;
    logic                  thermal_s;
    logic                  uv2_s;
    logic                  pump_s;
    logic                  vdd_s;
    logic [1:0]            drop_s;
    logic [1:0]            full_s;

    logic                  wr_en;
    logic                  rd_en;
    logic [3:0]            cmd;
    logic                  status_cmd;

    logic                  tsd_reg;
    logic                  uv2_reg;
    logic                  cp_reg;
    logic                  vdd_reg;
    logic                  eldef_reg;
    logic                  steploss_reg;
    logic                  stop_reg;
    logic                  status_seen_reg;
    logic                  electrical_fault_any;
    logic                  shutdown_cause;
    logic                  secure_enable;
    logic [10:0]           secure_position;
    logic [7:0]            vmax_reg;
    logic [7:0]            vmin_reg;
    logic [7:0]            dual_vmax_reg;
    logic [7:0]            dual_vmin_reg;
    logic                  shape_work_reg;
    logic [1:0]            stab_busy_reg;
    logic [CW-1:0]         stab_cnt_reg;
    logic [CW-1:0]         open_cnt_reg [2];
    logic [1:0]            open_flag;
    logic [31:0]           snap_reg;

    // fault monitors pass two flops before use
    smfs_sync #(.WIDTH(4)) u_sync_lvl
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({thermal_hot, uv2_low, pump_low, supply_reset_seen}),
        .sync_out (mon_s)
    );

    smfs_sync #(.WIDTH(4)) u_sync_coil
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({bridge_drop, coil_full_duty}),
        .sync_out ({drop_s, full_s})
    );

    assign thermal_s = mon_s[3];
    assign uv2_s     = mon_s[2];
    assign pump_s    = mon_s[1];
    assign vdd_s     = mon_s[0];

    // apb decode: zero wait state, errors on unmapped
    assign wr_en      = psel && penable && pwrite;
    assign rd_en      = psel && !penable && !pwrite;
    assign cmd        = (wr_en && paddr == SMFS_OFS_CMD) ? pwdata[3:0] : SMFS_CMD_NONE;
    assign status_cmd = (cmd == SMFS_CMD_STATUS);

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= SMFS_OFS_SNAP) && (a[1:0] == 2'b00);
    endfunction : mapped

    assign electrical_fault_any = cp_reg | uv2_reg | eldef_reg | vdd_reg;
    assign shutdown_cause = tsd_reg | uv2_reg | eldef_reg | cp_reg;
    assign secure_enable = (secure_position != SMFS_SEC_DISABLE);

    // sticky flags; live condition wins over the clear
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            tsd_reg   <= 1'b0;
            uv2_reg   <= 1'b0;
            cp_reg    <= 1'b0;
            vdd_reg   <= 1'b1;
            eldef_reg <= 1'b0;
        end
        else
        begin
            tsd_reg   <= thermal_s | (tsd_reg & ~status_cmd);
            uv2_reg   <= uv2_s | (uv2_reg & ~status_cmd);
            cp_reg    <= pump_s | (cp_reg & ~status_cmd);
            vdd_reg   <= vdd_s | (vdd_reg & ~status_cmd);
            // coil defect from drop or open coil
            eldef_reg <= (|drop_s) | (|open_flag) | (eldef_reg & ~status_cmd);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_open
            assign open_flag[gi] = (open_cnt_reg[gi] == CW'(OPEN_CYCLES));
            always_ff @(posedge core_clk)
            begin
                if (!rst_n || !full_s[gi])
                    open_cnt_reg[gi] <= '0;
                else if (!open_flag[gi])
                    open_cnt_reg[gi] <= open_cnt_reg[gi] + 1'b1;
            end
        end
    endgenerate

    // step loss, cleared only by status read; set wins
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            steploss_reg <= 1'b0;
        else if ((pump_s && (state_reg == SMFS_ST_MOVING || state_reg == SMFS_ST_DUAL))
                 || (cmd == SMFS_CMD_HARD && state_reg != SMFS_ST_STOPPED
                     && state_reg != SMFS_ST_SHUTDOWN))
            steploss_reg <= 1'b1;   // lost steps mid motion
        else if (status_cmd)
            steploss_reg <= 1'b0;
    end

    // status read latch for shutdown exit
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            status_seen_reg <= 1'b0;
        else if (state_reg != SMFS_ST_SHUTDOWN)
            status_seen_reg <= 1'b0;
        else if (status_cmd)
            status_seen_reg <= 1'b1;
    end

    // state transitions
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SMFS_ST_SHUTDOWN:
                // exit needs read and no causes
                if (status_seen_reg && !tsd_reg && !electrical_fault_any && !thermal_s)
                    state_next = SMFS_ST_STOPPED;
            SMFS_ST_STOPPED:
                if (shutdown_cause)
                    state_next = SMFS_ST_SHUTDOWN;
                else if (cmd == SMFS_CMD_DUAL)
                    state_next = SMFS_ST_DUAL;
                else if (!stop_reg && actual_position != target_position)
                    state_next = SMFS_ST_MOVING;
            SMFS_ST_MOVING, SMFS_ST_DUAL:
                if (pump_s || uv2_reg || eldef_reg || cmd == SMFS_CMD_HARD)
                    state_next = SMFS_ST_HARD;
                else if (tsd_reg || cmd == SMFS_CMD_SOFT)
                    state_next = SMFS_ST_RAMPED;
                else if ((state_reg == SMFS_ST_MOVING && decel_done) || dual_done)
                    state_next = SMFS_ST_STOPPED;
            SMFS_ST_HARD, SMFS_ST_RAMPED:
                if (decel_done)
                    state_next = SMFS_ST_STOPPED;
            default:
                state_next = SMFS_ST_SHUTDOWN;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            state_reg <= SMFS_ST_SHUTDOWN;  // shutdown after reset
        else
            state_reg <= state_next;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            stop_reg <= 1'b0;
        else if ((state_reg == SMFS_ST_HARD || state_reg == SMFS_ST_RAMPED)
                 && state_next != state_reg)
            stop_reg <= 1'b1;
        else if (state_reg == SMFS_ST_STOPPED)
            stop_reg <= 1'b0;
    end

    // target position updates
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            target_position <= '0;
        // copy actual on every cycle the next state is shutdown, and at halt end
        else if (state_next == SMFS_ST_SHUTDOWN
                 || ((state_reg == SMFS_ST_HARD || state_reg == SMFS_ST_RAMPED)
                     && state_next == SMFS_ST_STOPPED))
            target_position <= actual_position;
        else if (cmd == SMFS_CMD_CLRPOS
                 && (state_reg == SMFS_ST_STOPPED || state_reg == SMFS_ST_SHUTDOWN))
            target_position <= '0;
        else if (!steploss_reg && cmd == SMFS_CMD_SETPOS
                 && (state_reg == SMFS_ST_STOPPED || state_reg == SMFS_ST_MOVING))
            target_position <= pwdata[31:16];
        else if (!steploss_reg && cmd == SMFS_CMD_GOSEC && secure_enable
                 && (state_reg == SMFS_ST_STOPPED || state_reg == SMFS_ST_MOVING))
            target_position <= {{(SMFS_POS_W-11){secure_position[10]}}, secure_position};
    end

    // parameter writes; values take effect at once, even mid move
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pwm_rate_select   <= 1'b0;
            pwm_jitter_enable <= 1'b0;
            shape_work_reg    <= 1'b0;
            secure_position   <= SMFS_SEC_DISABLE;
            vmax_reg          <= SMFS_VEL_RESET;
            vmin_reg          <= SMFS_VEL_RESET;
        end
        else if (cmd == SMFS_CMD_DEFAULTS)
        begin
            pwm_rate_select   <= 1'b0;
            pwm_jitter_enable <= 1'b0;
            shape_work_reg    <= 1'b0;
        end
        else if (wr_en && paddr == SMFS_OFS_CTRL)
        begin
            pwm_rate_select   <= pwdata[SMFS_CTRL_PWMSEL];
            pwm_jitter_enable <= pwdata[SMFS_CTRL_JITTER];
            shape_work_reg    <= pwdata[SMFS_CTRL_SHAPE];
        end
        else if (wr_en && paddr == SMFS_OFS_SECURE)
            secure_position <= pwdata[10:0];
        else if (wr_en && paddr == SMFS_OFS_VEL)
        begin
            vmax_reg <= pwdata[7:0];
            vmin_reg <= pwdata[15:8];
        end
    end

    // private dual set, copied at sequence start
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            dual_vmax_reg <= SMFS_VEL_RESET;
            dual_vmin_reg <= SMFS_VEL_RESET;
        end
        else if (state_reg == SMFS_ST_STOPPED && state_next == SMFS_ST_DUAL)
        begin
            dual_vmax_reg <= (pwdata[15:8] != 8'h00) ? pwdata[15:8] : vmax_reg;
            dual_vmin_reg <= (pwdata[23:16] != 8'h00) ? pwdata[23:16] : vmin_reg;
        end
    end

    // shape forced during second dual motion
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            acceleration_shape <= 1'b0;
        else
            acceleration_shape <= (state_reg == SMFS_ST_DUAL && dual_phase_two)
                                  | shape_work_reg;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            stab_busy_reg <= 2'b00;
            stab_cnt_reg  <= '0;
        end
        else if (state_next == SMFS_ST_MOVING || state_next == SMFS_ST_DUAL)
            stab_busy_reg <= 2'b00;
        else if (state_reg != SMFS_ST_STOPPED && state_next == SMFS_ST_STOPPED
                 && state_reg != SMFS_ST_SHUTDOWN)
        begin
            stab_busy_reg <= 2'b01;
            stab_cnt_reg  <= CW'(STAB_CYCLES - 1);
        end
        else if (stab_busy_reg == 2'b01)
        begin
            if (stab_cnt_reg == '0)
                stab_busy_reg <= 2'b00;
            else
                stab_cnt_reg <= stab_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            bridge_open <= 2'b11;
            amp_select  <= SMFS_AMP_OFF;
        end
        else
        begin
            bridge_open <= (state_next == SMFS_ST_SHUTDOWN) ? 2'b11 : drop_s;
            if (state_next == SMFS_ST_SHUTDOWN)
                amp_select <= SMFS_AMP_OFF;
            else if (state_next == SMFS_ST_MOVING || state_next == SMFS_ST_DUAL)
                amp_select <= SMFS_AMP_RUN;
            else if (state_next == SMFS_ST_STOPPED && stab_busy_reg == 2'b00
                     && state_reg == SMFS_ST_STOPPED)
                amp_select <= SMFS_AMP_HOLD;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            snap_reg <= '0;
        else if (status_cmd)
            snap_reg <= {vmin_reg, vmax_reg, 8'h00, tsd_reg, uv2_reg, cp_reg, vdd_reg,
                         eldef_reg, steploss_reg, electrical_fault_any, pwm_jitter_enable};
    end

    // bus answers in every state, read data in setup
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            if (rd_en)
            begin
                case (paddr)
                    SMFS_OFS_CTRL:    prdata <= {23'h0, shape_work_reg, 1'b0,
                                                 pwm_rate_select, 5'h0, pwm_jitter_enable};
                    SMFS_OFS_TARGET:  prdata <= {target_position, 16'h0000};
                    SMFS_OFS_SECURE:  prdata <= {20'h0_0000, secure_enable, secure_position};
                    SMFS_OFS_STATUS:  prdata <= {21'h0, stop_reg, state_reg, tsd_reg, uv2_reg,
                                                 cp_reg, vdd_reg, eldef_reg, steploss_reg,
                                                 electrical_fault_any};
                    SMFS_OFS_ACTUAL:  prdata <= {16'h0000, actual_position};
                    SMFS_OFS_VEL:     prdata <= {16'h0000, vmin_reg, vmax_reg};
                    SMFS_OFS_DUALVEL: prdata <= {16'h0000, dual_vmin_reg, dual_vmax_reg};
                    SMFS_OFS_SNAP:    prdata <= snap_reg;
                    default:          prdata <= '0;
                endcase
            end
        end
    end

    // state seen outside for the step engine
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            motion_state <= 3'b000;
        else
            motion_state <= state_next;
    end

endmodule : smfs_supervisor

//--- verif/smfs_supervisor_sva.sv
// Purpose: port-level checks on the motion fault supervisor
// Assumes: sync sampled monitors settle within a few cycles
// Notes:   attached by bind below
`timescale 1ns/1ns
module smfs_supervisor_sva
    import smfs_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // monitors and engine
    input wire logic        thermal_hot,
    input wire logic        pump_low,
    input wire logic [1:0]  bridge_drop,
    input wire logic        decel_done,
    // drive outputs
    input wire logic [1:0]  bridge_open,
    input wire logic [1:0]  amp_select,
    input wire logic        pwm_rate_select,
    input wire logic        pwm_jitter_enable,
    input wire logic [2:0]  motion_state
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // slack of eight cycles covers the two-flop monitor synchronisers
    a_float_in_shutdown: assert property (motion_state == SMFS_ST_SHUTDOWN
        |-> bridge_open == 2'b11)
        else $error("bridges driven in shutdown");
    a_drop_opens_bridge: assert property ($rose(bridge_drop[0]) |-> ##[1:8] bridge_open[0])
        else $error("bridge not opened after drop");
    a_pump_stops_move: assert property ($rose(pump_low) && motion_state == SMFS_ST_MOVING
        |-> ##[1:8] motion_state != SMFS_ST_MOVING)
        else $error("pump failure did not stop motion");
    a_hot_keeps_down: assert property (motion_state == SMFS_ST_SHUTDOWN && thermal_hot
        && $past(thermal_hot, 4) |=> motion_state == SMFS_ST_SHUTDOWN)
        else $error("shutdown left while hot");
    a_run_while_moving: assert property (motion_state == SMFS_ST_MOVING
        && $past(motion_state) == SMFS_ST_MOVING |-> amp_select == SMFS_AMP_RUN)
        else $error("no run current while moving");
    a_stab_holds_level: assert property (decel_done |=> (amp_select != SMFS_AMP_HOLD) [*4])
        else $error("hold current before stabilization");
    a_rate_from_ctrl: assert property (psel && penable && pwrite && paddr == SMFS_OFS_CTRL
        |=> pwm_rate_select == $past(pwdata[SMFS_CTRL_PWMSEL]))
        else $error("pwm rate select not taken");
    a_jitter_from_ctrl: assert property (psel && penable && pwrite && paddr == SMFS_OFS_CTRL
        |=> pwm_jitter_enable == $past(pwdata[SMFS_CTRL_JITTER]))
        else $error("jitter enable not taken");
    a_refuse_unmapped: assert property (psel && penable && paddr > SMFS_OFS_SNAP
        |-> pslverr)
        else $error("unmapped access not refused");
    a_zero_wait_answer: assert property (psel && !penable |=> pready)
        else $error("apb answer late");
    c_moving: cover property (motion_state == SMFS_ST_MOVING);
    c_exit: cover property (motion_state == SMFS_ST_STOPPED && $past(motion_state) == 3'h0);
    c_refused: cover property (pslverr);
endmodule : smfs_supervisor_sva

bind smfs_supervisor smfs_supervisor_sva u_sva (.*);

//--- verif/smfs_apb_mst.sv
// Purpose: apb master standing in for the command host
// Assumes: slave may stretch access with pready low
// Notes:   bus changes only by nonblocking writes after a rising edge
`timescale 1ns/1ns
module smfs_apb_mst
(
    // clock
    input  wire logic        core_clk,
    // request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    // answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic [31:0] rdat;
    logic        rerr;
    initial
        {psel, penable, pwrite, paddr, pwdata} = '0;
    // one command at a time, no retuning mid move, few status retries
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released data is scrambled so stale values cannot pass
        pwdata  <= ~d;
        #1;
    endtask : xfer
endmodule : smfs_apb_mst

//--- verif/smfs_supervisor_tb_top.sv
// Purpose: self-checking bench for the motion fault supervisor
// Assumes: short stabilization and open-coil counts of 8
// Notes:   motion engine and monitors are driven here
`timescale 1ns/1ns
module smfs_supervisor_tb_top;
    import smfs_pkg::*;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic thermal_hot, uv2_low, pump_low, supply_reset_seen, decel_done;
    logic dual_phase_two, dual_done, pwm_rate_select, pwm_jitter_enable, acceleration_shape;
    logic [1:0] bridge_drop, coil_full_duty, bridge_open, amp_select;
    logic [2:0] motion_state;
    logic [7:0] paddr;
    logic [15:0] actual_position, target_position, tgt;
    logic [31:0] pwdata, prdata, d;
    int seed, k, samples_checked, n_mismatch;
    smfs_supervisor #(.STAB_CYCLES(8), .OPEN_CYCLES(8)) dut_u (.*);
    smfs_apb_mst u_mst (.*);
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cmd(input logic [3:0] c, input logic [31:0] v);
        u_mst.xfer(1'b1, SMFS_OFS_CMD, v | 32'(c));
    endtask : cmd
    // bounded wait, caller compares the state
    task automatic wait_st(input logic [2:0] s);
        for (int i = 0; i < 200 && motion_state !== s; i++)
            @(posedge core_clk);
        #1;
    endtask : wait_st
    // motion engine reports the halt finished
    task automatic halt_end;
        @(posedge core_clk) decel_done <= 1'b1;
        @(posedge core_clk) decel_done <= 1'b0;
    endtask : halt_end
    // status read once faults are gone, expect a clean exit
    task automatic recover;
        repeat (6) @(posedge core_clk);
        cmd(SMFS_CMD_STATUS, 0);
        wait_st(SMFS_ST_STOPPED);
        chk("exit", motion_state, SMFS_ST_STOPPED);
    endtask : recover
    initial
    begin
        seed = 36485;
        {rst_n, thermal_hot, uv2_low, pump_low, supply_reset_seen, decel_done} = '0;
        {dual_phase_two, dual_done, bridge_drop, coil_full_duty} = '0;
        actual_position = 16'h0000;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk("reset state", motion_state, SMFS_ST_SHUTDOWN);
        chk("reset bridges", bridge_open, 2'b11);
        u_mst.xfer(1'b0, SMFS_OFS_STATUS, 0);
        chk("vdd and electrical_fault_any", {u_mst.rdat[3], u_mst.rdat[0]}, 2'b11);
        @(posedge core_clk) thermal_hot <= 1'b1;
        repeat (6) @(posedge core_clk);
        cmd(SMFS_CMD_STATUS, 0);
        repeat (10) @(posedge core_clk);
        chk("hot stays down", motion_state, SMFS_ST_SHUTDOWN);
        @(posedge core_clk) thermal_hot <= 1'b0;
        recover();
        for (k = 0; k < 8; k++)
        begin
            d = $random(seed);
            u_mst.xfer(1'b1, SMFS_OFS_CTRL, d);
            chk("pwm rate", pwm_rate_select, d[SMFS_CTRL_PWMSEL]);
            chk("jitter", pwm_jitter_enable, d[SMFS_CTRL_JITTER]);
        end
        repeat (2) @(posedge core_clk);
        chk("shape", acceleration_shape, d[SMFS_CTRL_SHAPE]);
        tgt = 16'($random(seed)) | 16'h0001;
        cmd(SMFS_CMD_SETPOS, {tgt, 16'h0000});
        wait_st(SMFS_ST_MOVING);
        chk("target", target_position, tgt);
        repeat (2) @(posedge core_clk);
        chk("run amp", amp_select, SMFS_AMP_RUN);
        @(posedge core_clk) actual_position <= tgt;
        halt_end();
        repeat (4) @(posedge core_clk);
        chk("stab amp", amp_select, SMFS_AMP_RUN);
        repeat (16) @(posedge core_clk);
        chk("hold amp", amp_select, SMFS_AMP_HOLD);
        @(posedge core_clk) actual_position <= tgt ^ 16'h0005;
        wait_st(SMFS_ST_MOVING);
        chk("mismatch moves", motion_state, SMFS_ST_MOVING);
        @(posedge core_clk) pump_low <= 1'b1;
        wait_st(SMFS_ST_HARD);
        halt_end();
        wait_st(SMFS_ST_SHUTDOWN);
        chk("pump down", motion_state, SMFS_ST_SHUTDOWN);
        chk("target copy", target_position, tgt ^ 16'h0005);
        u_mst.xfer(1'b0, SMFS_OFS_STATUS, 0);
        chk("cp and steploss", {u_mst.rdat[4], u_mst.rdat[1]}, 2'b11);
        @(posedge core_clk) pump_low <= 1'b0;
        recover();
        // hard stop mid move leaves step loss set in stopped
        cmd(SMFS_CMD_SETPOS, {tgt, 16'h0000});
        cmd(SMFS_CMD_HARD, 0);
        halt_end();
        cmd(SMFS_CMD_SETPOS, {~tgt, 16'h0000});
        chk("blocked setpos", target_position, tgt ^ 16'h0005);
        for (k = 0; k < 2; k++)
        begin
            @(posedge core_clk) {coil_full_duty, bridge_drop} <= (k == 0) ? 4'h1 : 4'h8;
            wait_st(SMFS_ST_SHUTDOWN);
            chk("coil fault", {motion_state, bridge_open}, {SMFS_ST_SHUTDOWN, 2'b11});
            u_mst.xfer(1'b0, SMFS_OFS_STATUS, 0);
            chk("eldef", u_mst.rdat[2], 1'b1);
            @(posedge core_clk) {coil_full_duty, bridge_drop} <= 4'h0;
            recover();
        end
        u_mst.xfer(1'b0, 8'h24, 0);
        chk("unmapped err", u_mst.rerr, 1'b1);
        chk("unmapped data", u_mst.rdat, 0);
        results();
    end
    initial
    begin
        #200000;
        n_mismatch++;
        results();
    end
endmodule : smfs_supervisor_tb_top
